// File: rtl/rcr_pkg.sv
// Constants, field layouts and carriers for the column renderer
// Operation
// (RQ1) Keep one 30-bit record per column: start, span, axis, texture, texel column.
// (RQ2) Per pixel, fetch its column record and classify ceiling, wall or floor.
// (RQ3) Rows above wall start are ceiling; wall begins on the start row.
// (RQ4) Span rows from start are wall; rows below the span are floor.
// (RQ5) Ceiling and floor use fixed colours, with an optional vertical gradient.
// (RQ6) Wall pixels scale their row into the texture and read that texel.
// (RQ7) Axis flag selects darker or plain wall shading.
// (RQ8) Texture select picks one of eight stored textures.
// (RQ9) Texel column field picks the texture column for the whole column.
// (RQ10) Each texture is a 64 by 64 array of RGB texels.
// (RQ11) Each record describes exactly one single-pixel-wide screen column.
// (RQ12) No column index is sent; an internal index advances per record.
// (RQ13) Host requests, waits for grant, then writes records one per cycle.
// (RQ14) Grant is withheld until vertical blanking so frames never tear.
// (RQ15) Optional shadow array takes writes anytime, copied in blanking on flag.
// (RQ16) A missing record is tolerated; the device simply waits for the next.
// (RQ17) Registers hold a one-bit write request and a one-bit write permitted flag.
// (RQ18) Record data register holds the zero-padded record; writing stores it.
// (RQ19) Granting a new request resets the column index to zero.
// (RQ20) Record fields are packed from the top: start, span, axis, texture, column.
package rcr_pkg;

  localparam int          NUM_COLS   = 480;
  localparam logic [8:0]  LAST_COL   = 9'h1DF;
  localparam int          REC_W      = 30;
  localparam int          TEX_DIM_LG = 6;
  localparam int          TEX_WORDS  = 8 * 64 * 64;

  // Register word offsets (byte addresses)
  localparam logic [7:0] OFS_WRITE_REQUEST   = 8'h00;
  localparam logic [7:0] OFS_WRITE_PERMITTED = 8'h04;
  localparam logic [7:0] OFS_RECORD_DATA     = 8'h08;
  localparam logic [7:0] OFS_CONTROL         = 8'h0C;
  localparam logic [7:0] OFS_TEX_ADDR        = 8'h10;
  localparam logic [7:0] OFS_TEX_DATA        = 8'h14;
  localparam logic [7:0] OFS_STATUS          = 8'h18;

  // Control bit positions and reset value
  localparam int         CTL_SHADOW_BIT = 0;
  localparam int         CTL_COPY_BIT   = 1;
  localparam int         CTL_GRAD_BIT   = 2;
  localparam logic [2:0] CTL_RESET      = 3'h0;

  // Fixed colours
  localparam logic [23:0] CEIL_RGB  = 24'h5060A0;
  localparam logic [23:0] FLOOR_RGB = 24'h604830;
  localparam logic [23:0] BLANK_RGB = 24'h000000;

  typedef enum {CLS_NONE, CLS_CEIL, CLS_WALL, CLS_FLOOR} rcr_class_e;
  typedef enum {XF_IDLE, XF_WAIT, XF_OPEN} rcr_xfer_e;

  typedef struct packed {
    logic [9:0] start;
    logic [9:0] span;
    logic       side;
    logic [2:0] tex_sel;
    logic [5:0] tex_col;
  } rcr_rec_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rcr_bus_s;

  typedef struct packed {
    logic       active;
    logic       vblank;
    logic [9:0] x;
    logic [9:0] y;
  } rcr_pix_s;

endpackage

// File: rtl/rcr_renderer.sv
// Column record store, handshake and per-pixel renderer
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
module rcr_renderer (
  // Clock, reset, enable
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          ce_in,
  // Register port
  input  wire rcr_pkg::rcr_bus_s bus_in,
  output logic [31:0]        rdata_out,
  // Video timing
  input  wire rcr_pkg::rcr_pix_s pix_in,
  output logic [23:0]        rgb_out,
  output logic               rgb_valid_out
);
  import rcr_pkg::*;

  typedef struct packed {
    rcr_xfer_e   xfer;
    logic        req;
    logic        shadow_en;
    logic        copy_req;
    logic        grad_en;
    logic [8:0]  col_idx;
    logic [8:0]  copy_idx;
    logic [14:0] tex_waddr;
    logic [31:0] rd_data;
    logic        v1;
    logic [9:0]  y1;
    rcr_rec_s    rec1;
    rcr_class_e  cls2;
    logic        side2;
    logic [9:0]  y2;
    logic [14:0] taddr2;
    logic        v2;
    logic [23:0] rgb3;
    logic        v3;
  } rcr_state_s;

  rcr_state_s st_reg;
  rcr_state_s st_next;

  // Memories kept outside the state struct so they map to RAM
  rcr_rec_s    disp_mem   [NUM_COLS];
  rcr_rec_s    shadow_mem [NUM_COLS];
  logic [23:0] tex_mem    [TEX_WORDS];

  logic        disp_we;
  logic [8:0]  disp_waddr;
  rcr_rec_s    disp_wdata;
  logic        shadow_we;
  logic        tex_we;
  logic        rec_wr;
  logic        grant;
  logic [10:0] wall_end;
  logic [9:0]  wall_off;
  logic [15:0] scaled;
  logic [5:0]  tex_row;
  logic [23:0] texel;

  function automatic logic [23:0] shade(input logic [23:0] c, input logic dark);
    logic [23:0] r;
    r = c;
    if (dark) begin
      // Three quarters per channel: shifts only, no multiplier
      r = {c[23:16] - {2'h0, c[23:18]}, c[15:8] - {2'h0, c[15:10]},
           c[7:0] - {2'h0, c[7:2]}};
    end
    return r;
  endfunction

  function automatic logic [23:0] grad(input logic [23:0] c, input logic [9:0] y,
                                       input logic en);
    logic [7:0] d;
    d = en ? {4'h0, y[9:6]} : 8'h00;
    // Base colours sit above 0x10 per channel, so no underflow
    return {c[23:16] - d, c[15:8] - d, c[7:0] - d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    st_next    = st_reg;
    disp_we    = 1'b0;
    disp_waddr = st_reg.col_idx;
    disp_wdata = rcr_rec_s'(bus_in.wdata[REC_W-1:0]);
    shadow_we  = 1'b0;
    tex_we     = 1'b0;
    grant      = 1'b0;
    rec_wr     = bus_in.wr && (bus_in.addr == OFS_RECORD_DATA);

    // Register writes
    if (bus_in.wr) begin
      if (bus_in.addr == OFS_WRITE_REQUEST) begin
        st_next.req = bus_in.wdata[0]; // [RQ17]
      end else if (bus_in.addr == OFS_WRITE_PERMITTED) begin
        if (!bus_in.wdata[0]) begin
          st_next.req = 1'b0;
        end
      end else if (bus_in.addr == OFS_CONTROL) begin
        st_next.shadow_en = bus_in.wdata[CTL_SHADOW_BIT];
        st_next.grad_en   = bus_in.wdata[CTL_GRAD_BIT];
      end else if (bus_in.addr == OFS_TEX_ADDR) begin
        st_next.tex_waddr = bus_in.wdata[14:0];
      end else if (bus_in.addr == OFS_TEX_DATA) begin
        tex_we            = 1'b1;
        st_next.tex_waddr = st_reg.tex_waddr + 15'h0001;
      end
    end

    // Transfer handshake
    case (st_reg.xfer)
      XF_IDLE: begin
        if (st_reg.req) begin
          st_next.xfer = XF_WAIT;
        end
      end
      XF_WAIT: begin
        if (!st_reg.req) begin
          st_next.xfer = XF_IDLE;
        end else if (st_reg.shadow_en || pix_in.vblank) begin // [RQ14] [RQ15]
          st_next.xfer    = XF_OPEN;
          st_next.col_idx = 9'h000; // [RQ19]
          grant           = 1'b1;
        end
      end
      XF_OPEN: begin
        // Gaps between records are fine: no timeout exists [RQ16]
        if (rec_wr && st_reg.col_idx <= LAST_COL) begin // [RQ13]
          if (st_reg.shadow_en) begin
            shadow_we = 1'b1; // [RQ15]
          end else if (pix_in.vblank) begin
            // A late record after blanking ends is dropped, never shown mid frame [RQ14]
            disp_we = 1'b1; // [RQ18]
          end
          st_next.col_idx = st_reg.col_idx + 9'h001; // [RQ12] [RQ11]
        end
        if (!st_reg.req) begin
          st_next.xfer = XF_IDLE;
        end else if (!st_reg.shadow_en && !pix_in.vblank) begin
          // Blanking ended: the grant lapses, host must request again [RQ14]
          st_next.xfer = XF_IDLE;
          st_next.req  = 1'b0;
        end
      end
      default: begin
        st_next.xfer = XF_IDLE;
      end
    endcase

    // Shadow copy, one column per cycle, only in blanking; pauses if it ends
    if (st_reg.copy_req && pix_in.vblank && !disp_we) begin // [RQ15]
      disp_we    = 1'b1;
      disp_waddr = st_reg.copy_idx;
      disp_wdata = shadow_mem[st_reg.copy_idx];
      if (st_reg.copy_idx == LAST_COL) begin
        st_next.copy_req = 1'b0;
      end else begin
        st_next.copy_idx = st_reg.copy_idx + 9'h001;
      end
    end

    // A new copy request wins over completion in the same cycle
    if (bus_in.wr && bus_in.addr == OFS_CONTROL && bus_in.wdata[CTL_COPY_BIT]) begin // [RQ15]
      st_next.copy_req = 1'b1;
      st_next.copy_idx = 9'h000;
    end

    // Register reads, data stand one cycle later
    st_next.rd_data = 32'h0000_0000;
    if (bus_in.rd) begin
      if (bus_in.addr == OFS_WRITE_REQUEST) begin
        st_next.rd_data = {31'h0, st_reg.req};
      end else if (bus_in.addr == OFS_WRITE_PERMITTED) begin
        st_next.rd_data = {31'h0, st_reg.xfer == XF_OPEN}; // [RQ17]
      end else if (bus_in.addr == OFS_CONTROL) begin
        st_next.rd_data = {29'h0, st_reg.grad_en, st_reg.copy_req, st_reg.shadow_en};
      end else if (bus_in.addr == OFS_TEX_ADDR) begin
        st_next.rd_data = {17'h0, st_reg.tex_waddr};
      end else if (bus_in.addr == OFS_STATUS) begin
        st_next.rd_data = {7'h0, st_reg.copy_idx, 7'h0, st_reg.col_idx};
      end
    end

    // Stage 1: fetch the record of this pixel's column
    st_next.v1 = pix_in.active && (pix_in.x < 10'(NUM_COLS));
    st_next.y1 = pix_in.y;
    st_next.rec1 = disp_mem[pix_in.x[8:0]]; // [RQ2]

    // Stage 2: classify and form texture address
    wall_end = {1'b0, st_reg.rec1.start} + {1'b0, st_reg.rec1.span};
    wall_off = st_reg.y1 - st_reg.rec1.start;
    scaled   = {wall_off, 6'h00} / {6'h00, st_reg.rec1.span}; // [RQ6]
    tex_row  = scaled[TEX_DIM_LG-1:0];
    st_next.v2    = st_reg.v1;
    st_next.y2    = st_reg.y1;
    st_next.side2 = st_reg.rec1.side;
    st_next.taddr2 = {st_reg.rec1.tex_sel, tex_row, st_reg.rec1.tex_col}; // [RQ8] [RQ9]
    if (!st_reg.v1) begin
      st_next.cls2 = CLS_NONE;
    end else if (st_reg.y1 < st_reg.rec1.start) begin
      st_next.cls2 = CLS_CEIL; // [RQ3]
    end else if ({1'b0, st_reg.y1} < wall_end) begin
      st_next.cls2 = CLS_WALL; // [RQ4]
    end else begin
      st_next.cls2 = CLS_FLOOR; // [RQ4]
    end

    // Stage 3: colour the pixel
    texel      = tex_mem[st_reg.taddr2]; // [RQ10]
    st_next.v3 = st_reg.v2;
    case (st_reg.cls2)
      CLS_CEIL:  st_next.rgb3 = grad(CEIL_RGB, st_reg.y2, st_reg.grad_en); // [RQ5]
      CLS_FLOOR: st_next.rgb3 = grad(FLOOR_RGB, ~st_reg.y2, st_reg.grad_en); // [RQ5]
      CLS_WALL:  st_next.rgb3 = shade(texel, st_reg.side2); // [RQ7]
      default:   st_next.rgb3 = BLANK_RGB;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and memories

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg           <= '0;
      st_reg.xfer      <= XF_IDLE;
      st_reg.cls2      <= CLS_NONE;
      st_reg.shadow_en <= CTL_RESET[CTL_SHADOW_BIT];
      st_reg.copy_req  <= CTL_RESET[CTL_COPY_BIT];
      st_reg.grad_en   <= CTL_RESET[CTL_GRAD_BIT];
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in && !rst_in) begin
      if (disp_we) begin
        disp_mem[disp_waddr] <= disp_wdata; // [RQ1] [RQ20]
      end
      if (shadow_we) begin
        shadow_mem[st_reg.col_idx] <= rcr_rec_s'(bus_in.wdata[REC_W-1:0]);
      end
      if (tex_we) begin
        tex_mem[st_reg.tex_waddr] <= bus_in.wdata[23:0];
      end
    end
  end

  assign rdata_out     = st_reg.rd_data;
  assign rgb_out       = st_reg.rgb3;
  assign rgb_valid_out = st_reg.v3;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_grant_in_blank;
    ce_in && st_reg.xfer == XF_WAIT && !st_reg.shadow_en && !pix_in.vblank
      |=> st_reg.xfer != XF_OPEN;
  endproperty
  a_grant_in_blank: assert property (p_grant_in_blank) // [RQ14]
    else $error("grant outside blank");

  property p_disp_write_blank;
    disp_we |-> pix_in.vblank;
  endproperty
  a_disp_write_blank: assert property (p_disp_write_blank) // [RQ14]
    else $error("display write mid frame");

  property p_grant_lapse;
    ce_in && st_reg.xfer == XF_OPEN && !st_reg.shadow_en && !pix_in.vblank
      |=> st_reg.xfer == XF_IDLE && !st_reg.req;
  endproperty
  a_grant_lapse: assert property (p_grant_lapse) // [RQ14]
    else $error("grant kept after blanking");

  property p_idx_reset;
    ce_in && grant |=> st_reg.col_idx == 9'h000 && st_reg.xfer == XF_OPEN;
  endproperty
  a_idx_reset: assert property (p_idx_reset) // [RQ19]
    else $error("index not cleared on grant");

  property p_rdata_idle;
    ce_in && !bus_in.rd |=> rdata_out == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // [RQ17]
    else $error("read data not cleared");

  property p_copy_hold;
    ce_in && !pix_in.vblank && !(bus_in.wr && bus_in.addr == OFS_CONTROL)
      |=> st_reg.copy_idx == $past(st_reg.copy_idx) && st_reg.copy_req == $past(st_reg.copy_req);
  endproperty
  a_copy_hold: assert property (p_copy_hold) // [RQ15]
    else $error("copy moved outside blanking");

  property p_copy_restart;
    ce_in && bus_in.wr && bus_in.addr == OFS_CONTROL && bus_in.wdata[CTL_COPY_BIT]
      |=> st_reg.copy_req && st_reg.copy_idx == 9'h000;
  endproperty
  a_copy_restart: assert property (p_copy_restart) // [RQ15]
    else $error("copy request lost");

  property p_shadow_hold;
    ce_in && st_reg.shadow_en && !st_reg.copy_req |-> !disp_we;
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) // [RQ15]
    else $error("display written in shadow mode");

  property p_idx_advance;
    ce_in && st_reg.xfer == XF_OPEN && rec_wr && st_reg.col_idx <= LAST_COL
      |=> st_reg.col_idx == $past(st_reg.col_idx) + 9'h001;
  endproperty
  a_idx_advance: assert property (p_idx_advance) // [RQ12]
    else $error("index did not advance");

  property p_ceiling;
    ce_in && st_reg.v1 && st_reg.y1 < st_reg.rec1.start |=> st_reg.cls2 == CLS_CEIL;
  endproperty
  a_ceiling: assert property (p_ceiling) // [RQ3]
    else $error("ceiling misclassified");

  property p_wall;
    ce_in && st_reg.v1 && st_reg.y1 >= st_reg.rec1.start && {1'b0, st_reg.y1} < wall_end
      |=> st_reg.cls2 == CLS_WALL;
  endproperty
  a_wall: assert property (p_wall) // [RQ4]
    else $error("wall misclassified");

  property p_floor;
    ce_in && st_reg.v1 && {1'b0, st_reg.y1} >= wall_end |=> st_reg.cls2 == CLS_FLOOR;
  endproperty
  a_floor: assert property (p_floor) // [RQ4]
    else $error("floor misclassified");

  property p_invalid_blank;
    ce_in && !st_reg.v2 |=> rgb_out == BLANK_RGB && !rgb_valid_out;
  endproperty
  a_invalid_blank: assert property (p_invalid_blank) // [RQ2]
    else $error("invalid pixel not blank");

  property p_tex_select;
    ce_in && st_reg.v1 |=> st_reg.taddr2[14:12] == $past(st_reg.rec1.tex_sel)
      && st_reg.taddr2[5:0] == $past(st_reg.rec1.tex_col);
  endproperty
  a_tex_select: assert property (p_tex_select) // [RQ8]
    else $error("texture address wrong");

  property p_tex_step;
    ce_in && bus_in.wr && bus_in.addr == OFS_TEX_DATA
      |=> st_reg.tex_waddr == $past(st_reg.tex_waddr) + 15'h0001;
  endproperty
  a_tex_step: assert property (p_tex_step) // [RQ10]
    else $error("texture address did not step");

  property p_fixed_ceiling;
    ce_in && st_reg.cls2 == CLS_CEIL && !st_reg.grad_en |=> rgb_out == CEIL_RGB;
  endproperty
  a_fixed_ceiling: assert property (p_fixed_ceiling) // [RQ5]
    else $error("ceiling colour wrong");

  property p_fixed_floor;
    ce_in && st_reg.cls2 == CLS_FLOOR && !st_reg.grad_en |=> rgb_out == FLOOR_RGB;
  endproperty
  a_fixed_floor: assert property (p_fixed_floor) // [RQ5]
    else $error("floor colour wrong");

  // Expected shading written per channel, independent of the shade function
  property p_shade;
    ce_in && st_reg.cls2 == CLS_WALL |=> $past(st_reg.side2)
      ? (rgb_out[23:16] == $past(texel[23:16]) - ($past(texel[23:16]) >> 2)
        && rgb_out[15:8] == $past(texel[15:8]) - ($past(texel[15:8]) >> 2)
        && rgb_out[7:0] == $past(texel[7:0]) - ($past(texel[7:0]) >> 2))
      : rgb_out == $past(texel);
  endproperty
  a_shade: assert property (p_shade) // [RQ7]
    else $error("wall shading wrong");

  c_grant: cover property (grant && !st_reg.shadow_en);
  c_lapse: cover property (st_reg.xfer == XF_OPEN && !st_reg.shadow_en && !pix_in.vblank);
  c_shadow_write: cover property (shadow_we);
  c_copy_done: cover property (st_reg.copy_req ##1 !st_reg.copy_req);
  c_wall_dark: cover property (st_reg.cls2 == CLS_WALL && st_reg.side2);

endmodule

// File: tb/rcr_host.sv
// Host driver model: register accesses and column record streaming
`timescale 1ns/1ns
module rcr_host (
  // Clock
  input  wire logic              clk_in,
  // Register port
  output rcr_pkg::rcr_bus_s      bus_out,
  input  wire logic [31:0]       rdata_in
);
  import rcr_pkg::*;

  initial bus_out = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Record packing, top field first
  function automatic logic [31:0] pack(input logic [9:0] s, input logic [9:0] n,
                                       input logic sd, input logic [2:0] t,
                                       input logic [5:0] c);
    rcr_rec_s r;
    r = '{start: s, span: n, side: sd, tex_sel: t, tex_col: c};
    pack = {2'h0, r};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles
  task automatic idle();
    bus_out.wr    <= 1'b0;
    bus_out.rd    <= 1'b0;
    // Released data never shows a stale value
    bus_out.wdata <= ~bus_out.wdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    idle();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: bus_out.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    idle();
    #1 d = rdata_in;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Request, wait for grant, then one record per clock with no column index
  task automatic stream(input logic [31:0] recs[$], input int gap_at, output logic ok);
    logic [31:0] f;
    ok = 1'b0;
    wr(OFS_WRITE_REQUEST, 32'h1);
    for (int i = 0; i < 20 && ok !== 1'b1; i++) begin
      rd(OFS_WRITE_PERMITTED, f);
      ok = f[0];
    end
    if (ok === 1'b1) begin
      foreach (recs[k]) begin
        if (k == gap_at) begin
          // A late record: the device must simply wait
          @(posedge clk_in);
          idle();
        end
        @(posedge clk_in);
        bus_out <= '{addr: OFS_RECORD_DATA, wdata: recs[k], wr: 1'b1, rd: 1'b0};
      end
      @(posedge clk_in);
      idle();
    end
    wr(OFS_WRITE_REQUEST, 32'h0);
  endtask
endmodule

// File: tb/rcr_renderer_test.sv
// Self-checking bench for the column renderer
`timescale 1ns/1ns
module rcr_renderer_test;
  import rcr_pkg::*;
  logic        clk_in;
  logic        rst_in;
  logic        ce_in;
  rcr_pix_s    pix;
  rcr_bus_s    bus;
  logic [31:0] rdata;
  logic [23:0] rgb;
  logic        rgb_valid;
  int          miscompares;
  int          check_count;
  int          cycles = 0;
  logic [31:0] d;
  logic        ok;
  logic [31:0] q[$];

  rcr_host host (.clk_in(clk_in), .bus_out(bus), .rdata_in(rdata));
  rcr_renderer dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .bus_in(bus),
                    .rdata_out(rdata), .pix_in(pix), .rgb_out(rgb), .rgb_valid_out(rgb_valid));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cycle count for the hang limit checked in the main block
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host.rd(a, v);
    check(v, exp);
  endtask

  // Hold one pixel until the pipe has settled, then compare
  task automatic px(input logic [9:0] x, input logic [9:0] y, input logic [23:0] exp);
    @(posedge clk_in);
    pix.active <= 1'b1;
    pix.x      <= x;
    pix.y      <= y;
    repeat (5) @(posedge clk_in);
    #1 check({7'h0, rgb_valid, rgb}, {7'h0, x < 10'h1E0, exp});
  endtask

  task automatic vb(input logic v);
    @(posedge clk_in);
    pix.vblank <= v;
  endtask

  function automatic logic [23:0] dark(input logic [23:0] c);
    for (int i = 0; i < 3; i++) dark[i*8 +: 8] = c[i*8 +: 8] - (c[i*8 +: 8] >> 2);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic run_tests();
    rchk(OFS_WRITE_REQUEST, 32'h0);
    rchk(OFS_WRITE_PERMITTED, 32'h0);
    rchk(OFS_CONTROL, 32'h0);
    rchk(8'h1C, 32'h0);
    // Textures: second data word lands on the next texel
    host.wr(OFS_TEX_ADDR, 32'h3004);
    host.wr(OFS_TEX_DATA, 32'h665544);
    host.wr(OFS_TEX_DATA, 32'h123456);
    host.wr(OFS_TEX_ADDR, 32'h3FC5);
    host.wr(OFS_TEX_DATA, 32'h8844CC);
    host.wr(OFS_TEX_ADDR, 32'h0005);
    host.wr(OFS_TEX_DATA, 32'h0A0B0C);
    // Request outside blanking must stay ungranted
    host.wr(OFS_WRITE_REQUEST, 32'h1);
    repeat (4) @(posedge clk_in);
    rchk(OFS_WRITE_PERMITTED, 32'h0);
    rchk(OFS_WRITE_REQUEST, 32'h1);
    // Writing zero to the flag withdraws the request
    host.wr(OFS_WRITE_PERMITTED, 32'h0);
    rchk(OFS_WRITE_REQUEST, 32'h0);
    q = {host.pack(10, 64, 0, 3, 5), host.pack(10, 64, 1, 3, 5), host.pack(300, 0, 0, 3, 5),
         host.pack(10, 64, 0, 0, 5), host.pack(10, 64, 0, 3, 4), host.pack(10, 128, 0, 3, 5)};
    vb(1'b1);
    host.stream(q, 2, ok);
    check({31'h0, ok}, 32'h1);
    host.rd(OFS_STATUS, d);
    check({23'h0, d[8:0]}, 32'h6);
    vb(1'b0);
    px(0, 9, CEIL_RGB);
    px(0, 10, 24'h123456);
    px(0, 73, 24'h8844CC);
    px(0, 74, FLOOR_RGB);
    px(1, 10, dark(24'h123456));
    px(2, 299, CEIL_RGB);
    px(2, 300, FLOOR_RGB);
    px(3, 10, 24'h0A0B0C);
    px(4, 10, 24'h665544);
    px(5, 11, 24'h123456);
    px(5, 137, 24'h8844CC);
    px(480, 10, 24'h0);
    // Gradient enabled: ceiling and floor shift with the row
    host.wr(OFS_CONTROL, 32'h4);
    px(2, 299, 24'h4C5C9C);
    px(2, 300, 24'h553D25);
    host.wr(OFS_CONTROL, 32'h0);
    // Enable low: a write in that cycle is dropped
    ce_in <= 1'b0;
    host.wr(OFS_WRITE_REQUEST, 32'h1);
    ce_in <= 1'b1;
    rchk(OFS_WRITE_REQUEST, 32'h0);
    // New transfer restarts at column 0
    vb(1'b1);
    host.stream('{host.pack(10, 64, 0, 0, 5)}, -1, ok);
    check({31'h0, ok}, 32'h1);
    vb(1'b0);
    px(0, 10, 24'h0A0B0C);
    px(1, 10, dark(24'h123456));
    // End of blanking takes the grant and the request with it
    vb(1'b1);
    host.wr(OFS_WRITE_REQUEST, 32'h1);
    repeat (2) @(posedge clk_in);
    rchk(OFS_WRITE_PERMITTED, 32'h1);
    vb(1'b0);
    rchk(OFS_WRITE_REQUEST, 32'h0);
    rchk(OFS_WRITE_PERMITTED, 32'h0);
    host.wr(OFS_RECORD_DATA, host.pack(10, 64, 0, 3, 4));
    px(0, 10, 24'h0A0B0C);
    // Shadow mode: display only changes after the blanking copy
    host.wr(OFS_CONTROL, 32'h1);
    host.stream('{host.pack(10, 64, 0, 3, 4)}, -1, ok);
    check({31'h0, ok}, 32'h1);
    px(0, 10, 24'h0A0B0C);
    host.wr(OFS_CONTROL, 32'h3);
    vb(1'b1);
    for (int i = 0; i < 400; i++) begin
      host.rd(OFS_CONTROL, d);
      if (d[1] === 1'b0) break;
    end
    check({31'h0, d[1]}, 32'h0);
    vb(1'b0);
    px(0, 10, 24'h665544);
  endtask

  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    pix = '0;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    // A hung handshake counts as a mismatch and still reaches the report
    fork
      run_tests();
      begin
        wait (cycles == 20000);
        miscompares++;
      end
    join_any
    close_out();
  end
endmodule
